//--- src/panel_pkg.sv
// Purpose: Shared constants and types for the scrambler front-panel controller.
// Assumes: One 25 MHz clock, asynchronous active-low reset.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package panel_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned DEBOUNCE_US = 10000;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1000000);

  localparam int unsigned NUM_WAVES = 6;
  localparam logic [2:0] WAVE_980 = 3'h0;
  localparam logic [2:0] WAVE_1550 = 3'h4;
  localparam logic [2:0] WAVE_LAST = 3'h5;
  localparam logic [2:0] WAVE_RESET = WAVE_1550;
  localparam logic SCRAMBLE_RESET = 1'b0;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Panel state carried to the lamps and the driver stage.
  typedef struct packed {
    logic [NUM_WAVES-1:0] wave_lamps;
    logic scramble_lamp;
    logic supply_lamp;
    logic driver_run;
  } panel_out_t;

  typedef enum logic [1:0] {
    BTN_IDLE,
    BTN_PRESSED,
    BTN_RELEASE
  } btn_state_t;

endpackage

//--- src/scramble_panel.sv
// Purpose: Front-panel control of a polarization scrambler, with AHB-Lite register access.
// Assumes: Buttons are active high and synchronous to hclk; supply_ok_in is a level.
// Notes: CTRL write bit0 sets scrambling, bits 6:4 set wavelength; a write has priority
//   over a press in the same cycle. STATUS reads wavelength, scrambling and supply.
//   Only haddr[7:0] is decoded, so both registers repeat every 256 bytes.
//   DEBOUNCE_LEN sets how many steady cycles make a press; a release needs DEBOUNCE_LEN + 1 steady low cycles.
//   driver_run high lets the driver stage run; low holds it idle.
//   Lamps are active high.
`timescale 1ns/1ps
module scramble_panel
  import panel_pkg::*;
#(
  parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scramble_btn,
  input wire logic wave_btn,
  input wire logic supply_ok_in,
  output panel_out_t panel
);

  logic [2:0] wave_reg;
  logic scramble_reg;
  logic supply_reg;
  logic scramble_press;
  logic wave_press;
  // Write address phase kept for its data phase, when hwdata is valid.
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic ctrl_wr;
  logic [31:0] rdata_next;

  // One debouncer per button so a held button yields a single pulse.
  btn_debounce #(.LEN(DEBOUNCE_LEN)) u_scr_db (
    .hclk(hclk),
    .hresetn(hresetn),
    .btn(scramble_btn),
    .press(scramble_press)
  );
  btn_debounce #(.LEN(DEBOUNCE_LEN)) u_wave_db (
    .hclk(hclk),
    .hresetn(hresetn),
    .btn(wave_btn),
    .press(wave_press)
  );

  // Bus slave: always zero wait states, OKAY response.
  // The address is captured every cycle; it only matters when wr_pend_reg is set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Only a write to CTRL changes state; writes elsewhere are dropped.
  assign ctrl_wr = wr_pend_reg && (wr_addr_reg == CTRL_OFFSET);

  // Read data reflects the state at the address phase of the read.
  always_comb begin
    rdata_next = UNMAPPED_DATA;
    if (haddr[7:0] == CTRL_OFFSET) begin
      rdata_next = {25'h0, wave_reg, 3'h0, scramble_reg};
    end else if (haddr[7:0] == STATUS_OFFSET) begin
      rdata_next = {24'h0, supply_reg, wave_reg, 3'h0, scramble_reg};
    end
  end

  // The ready and response outputs keep their reset values, so no transfer is stretched.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= UNMAPPED_DATA;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // Scrambling state: press toggles, software write overrides.
  // A write in the same cycle as a debounced press wins and the press is lost.
  // The driver command and the green lamp both follow this state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scramble_reg <= SCRAMBLE_RESET;
    end else if (ctrl_wr) begin
      scramble_reg <= hwdata[0];
    end else if (scramble_press) begin
      scramble_reg <= !scramble_reg;
    end
  end

  // Wavelength selection steps in fixed order and wraps.
  // A software write sets it directly and beats a press in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_reg <= WAVE_RESET;
    end else if (ctrl_wr) begin
      // An index past the last setting is ignored so one lamp stays lit.
      if (hwdata[6:4] <= WAVE_LAST) begin
        wave_reg <= hwdata[6:4];
      end
    end else if (wave_press) begin
      wave_reg <= (wave_reg == WAVE_LAST) ? WAVE_980 : wave_reg + 3'h1;
    end
  end

  // The supply level is registered for the status read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_reg <= 1'b0;
    end else begin
      supply_reg <= supply_ok_in;
    end
  end

  // Outputs are registered copies of the state; the supply lamp is registered from supply_ok_in.
  // The wavelength and scrambling lamps and driver command lag the state by one clock edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // The reset value already lights the power-up wavelength lamp.
      panel.wave_lamps <= NUM_WAVES'(1) << WAVE_RESET;
      panel.scramble_lamp <= 1'b0;
      panel.supply_lamp <= 1'b0;
      panel.driver_run <= 1'b0;
    end else begin
      panel.wave_lamps <= NUM_WAVES'(1) << wave_reg;
      panel.scramble_lamp <= scramble_reg;
      panel.driver_run <= scramble_reg;
      panel.supply_lamp <= supply_ok_in;
    end
  end

endmodule

// Debounces one active-high button and pulses once per stable press.
// A held button never repeats; a new press needs a clean release first.
module btn_debounce
  import panel_pkg::*;
#(
  parameter int unsigned LEN = DEBOUNCE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic btn,
  output logic press
);

  btn_state_t state_reg;
  // Counts steady cycles of the current level, up to LEN.
  logic [$clog2(LEN+1)-1:0] cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= BTN_IDLE;
      cnt_reg <= '0;
      press <= 1'b0;
    end else begin
      press <= 1'b0;
      case (state_reg)
        BTN_IDLE: begin
          // Any low sample restarts the count, so only a steady level counts.
          if (!btn) begin
            cnt_reg <= '0;
          end else if (cnt_reg == $bits(cnt_reg)'(LEN - 1)) begin
            cnt_reg <= '0;
            press <= 1'b1;
            state_reg <= BTN_PRESSED;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        BTN_PRESSED: begin
          // No pulse while held; wait for the button to be let go.
          if (!btn) begin
            state_reg <= BTN_RELEASE;
          end
        end
        BTN_RELEASE: begin
          // A bounce back high re-arms the wait for a steady release.
          if (btn) begin
            cnt_reg <= '0;
            state_reg <= BTN_PRESSED;
          end else if (cnt_reg == $bits(cnt_reg)'(LEN - 1)) begin
            cnt_reg <= '0;
            state_reg <= BTN_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= BTN_IDLE;
        end
      endcase
    end
  end

endmodule

//--- testbench/front_panel_scramble_control_tb.sv
// Purpose: Self-checking bench for the front-panel controller.
// Assumes: Debounce shortened to 4 cycles.
// Notes: Expected lamps and status follow from tracked state w and s.
`timescale 1ns/1ps
module front_panel_scramble_control_tb;
  import panel_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic supply_ok_in = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, scramble_btn, wave_btn, s = 1'b0;
  logic [2:0] w = WAVE_1550;
  panel_out_t panel;
  int err_total = 0, cmp_count = 0;
  always #20 hclk = ~hclk;
  scramble_panel #(.DEBOUNCE_LEN(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scramble_btn(scramble_btn), .wave_btn(wave_btn), .supply_ok_in(supply_ok_in),
    .panel(panel));
  panel_buttons i_btn (.hclk(hclk), .scramble_btn(scramble_btn), .wave_btn(wave_btn));
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n <= 50) begin
      n++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, hreadyout, 1'b1);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic look;
    // Lamps are registered from the state, so they lag a bus write by one edge.
    @(posedge hclk);
    @(negedge hclk);
    chk(32'(panel), {23'h0, 6'h01 << w, s, supply_ok_in, s});
  endtask
  task automatic stat;
    bus(STATUS_OFFSET, 1'b0, 32'h0);
    chk(q, {24'h0, supply_ok_in, w, 3'h0, s});
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    look();
    stat();
    for (int i = 0; i < 2; i++) begin
      i_btn.press(1'b0, 12);
      s = ~s;
      look();
    end
    for (int i = 0; i < 7; i++) begin
      i_btn.press(1'b1, 12);
      w = (w == WAVE_LAST) ? WAVE_980 : w + 3'h1;
      look();
    end
    i_btn.press(1'b1, 2);
    look();
    i_btn.press(1'b0, 12);
    s = 1'b1;
    look();
    bus(CTRL_OFFSET, 1'b1, 32'h70);
    s = 1'b0;
    look();
    bus(CTRL_OFFSET, 1'b1, 32'h21);
    w = 3'h2;
    s = 1'b1;
    look();
    bus(CTRL_OFFSET, 1'b0, 32'h0);
    chk(q, {25'h0, w, 3'h0, s});
    bus(8'h08, 1'b1, 32'hFFFFFFFF);
    bus(8'h08, 1'b0, 32'h0);
    chk(q, 32'h0);
    stat();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    w = WAVE_1550;
    s = 1'b0;
    look();
    stat();
    supply_ok_in <= 1'b0;
    @(posedge hclk);
    look();
    results();
  end
endmodule
bind scramble_panel panel_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .scramble_btn(scramble_btn), .wave_btn(wave_btn),
  .supply_ok_in(supply_ok_in), .hreadyout(hreadyout), .hresp(hresp), .panel(panel));

//--- testbench/panel_buttons.sv
// Purpose: Operator model pressing the two front-panel buttons.
// Assumes: Buttons are active-high levels.
// Notes: A short hold imitates a bounce that must not count.
`timescale 1ns/1ps
module panel_buttons (
  input wire logic hclk,
  output logic scramble_btn = 1'b0,
  output logic wave_btn = 1'b0
);
  task automatic press(input logic wave, input int hold);
    @(posedge hclk);
    if (wave)
      wave_btn <= 1'b1;
    else
      scramble_btn <= 1'b1;
    repeat (hold) @(posedge hclk);
    wave_btn <= 1'b0;
    scramble_btn <= 1'b0;
    // Released long enough that the next press is seen as new.
    repeat (12) @(posedge hclk);
  endtask
endmodule

//--- testbench/panel_checker.sv
// Purpose: Port-level assertions for the front-panel controller.
// Assumes: One clock, reset active low.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module panel_checker
  import panel_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic scramble_btn,
  input wire logic wave_btn,
  input wire logic supply_ok_in,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire panel_out_t panel
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  boot_lamps_a:
    assert property ($rose(hresetn) |=> panel.wave_lamps == 6'h10 && !panel.scramble_lamp)
    else $error("lamps wrong after reset");
  one_lamp_a:
    assert property ($past(hresetn) |-> $onehot(panel.wave_lamps))
    else $error("wavelength lamps not one-hot");
  driver_idle_a:
    assert property (panel.driver_run == panel.scramble_lamp)
    else $error("driver and lamp disagree");
  supply_lamp_a:
    assert property ($past(hresetn) |-> panel.supply_lamp == $past(supply_ok_in))
    else $error("supply lamp wrong");
  wave_step_a:
    assert property ($past(hresetn, 2) && $changed(panel.wave_lamps) &&
      !$past(hsel && htrans[1] && hwrite, 3) |->
      panel.wave_lamps == {$past(panel.wave_lamps[4:0]), $past(panel.wave_lamps[5])})
    else $error("wavelength step out of order");
  scr_cause_a:
    assert property ($changed(panel.scramble_lamp) |->
      $past(scramble_btn, 3) || $past(hsel && htrans[1] && hwrite, 3))
    else $error("scramble lamp changed with no press or write");
  wave_hold_a:
    assert property (wave_btn [*8] ##1 wave_btn ##1 wave_btn |-> $stable(panel.wave_lamps))
    else $error("held wavelength button stepped again");
  scr_hold_a:
    assert property (scramble_btn [*8] ##1 scramble_btn ##1 scramble_btn |->
      $stable(panel.scramble_lamp))
    else $error("held scramble button toggled again");
  bus_ok_a:
    assert property (hsel && htrans[1] |=> hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule
